// ---- shared/pwt_defs.svh ----
// Register offsets, field positions, reset values and widths of the pulse width timer.
// Assumes an 8-bit register port with byte offsets.
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH

// ==========================================
// Register offsets
`define PWT_OFS_CTRL_STATUS 3'h0
`define PWT_OFS_CONTROL 3'h1
`define PWT_OFS_POS_HIGH 3'h2
`define PWT_OFS_POS_LOW 3'h3
`define PWT_OFS_NEG_HIGH 3'h4
`define PWT_OFS_NEG_LOW 3'h5
`define PWT_OFS_CNT_HIGH 3'h6
`define PWT_OFS_CNT_LOW 3'h7

// ==========================================
// Control and status register fields
`define PWT_CS_EN 7
`define PWT_CS_IE 6
`define PWT_CS_RDYIE 5
`define PWT_CS_OVIE 4
`define PWT_CS_SR 3
`define PWT_CS_RDY 1
`define PWT_CS_OV 0

// ==========================================
// Control register fields
`define PWT_CR_CLKSEL 7
`define PWT_CR_PIN_HI 6
`define PWT_CR_PIN_LO 5
`define PWT_CR_EDGE_HI 4
`define PWT_CR_EDGE_LO 3
`define PWT_CR_DIV_HI 2
`define PWT_CR_DIV_LO 0

// ==========================================
// Reset values and edge modes
`define PWT_RST_BYTE 8'h00
`define PWT_RST_WORD 16'h0000
`define PWT_CNT_MAX 16'hFFFF
`define PWT_EDGE_FALL_PERIOD 2'h0
`define PWT_EDGE_RISE_FIRST 2'h1
`define PWT_EDGE_FALL_FIRST 2'h2
`define PWT_EDGE_RISE_PERIOD 2'h3

`endif

// ---- shared/pwt_pkg.sv ----
// Types of the pulse width timer: measurement states and the state records.
// Assumes the constants of pwt_defs.svh for the widths used elsewhere.
package pwt_pkg;

    // ==========================================
    // Measurement state
    typedef enum logic [1:0] {
        PWT_ST_WAIT = 2'b01,
        PWT_ST_RUN = 2'b10
    } pwt_state_t;

    // ==========================================
    // Main block state
    typedef struct packed {
        logic [7:0] cr;
        logic en;
        logic ie;
        logic rdyie;
        logic ovie;
        logic rdy;
        logic rdy_seen;
        logic ov;
        logic [15:0] cnt;
        logic [15:0] pos;
        logic [15:0] neg;
        logic [15:0] pos_buf;
        logic [15:0] neg_buf;
        logic [15:0] cnt_buf;
        logic lat;
        logic lat_low_first;
        pwt_state_t st;
        logic half;
        logic in_q;
        logic in_vld;
        logic clr;
        logic alt_s1;
        logic alt_s2;
        logic alt_s3;
        logic [7:0] rd_data;
        logic irq;
    } pwt_main_t;

    // ==========================================
    // Prescaler state
    typedef struct packed {
        logic [6:0] cnt;
    } pwt_pre_t;

endpackage : pwt_pkg

// ---- shared/pwt_pre_if.sv ----
// Link between the timer core and its clock prescaler.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ns
`default_nettype none

interface pwt_pre_if;
    logic src_tick;
    logic clear;
    logic [2:0] div;
    logic tick;

    modport ctl (output src_tick, output clear, output div, input tick);
    modport pre (input src_tick, input clear, input div, output tick);
endinterface : pwt_pre_if

`default_nettype wire

// ---- src/pwt_prescaler.sv ----
// Clock prescaler: divides the source tick enable by 2 to the power of div.
// Assumes src_tick is a one-cycle enable in the bus clock domain.
`timescale 1ns/1ns
`default_nettype none

module pwt_prescaler (
    input wire logic clk,
    input wire logic nrst,
    pwt_pre_if.pre pre
);
    pwt_pkg::pwt_pre_t s;
    pwt_pkg::pwt_pre_t n;
    logic [6:0] mask;

    // ==========================================
    // Divider
    always_comb begin
        n = s;
        mask = 7'h7F >> (3'h7 - pre.div); // RULE2
        if (pre.clear) begin
            n.cnt = 7'h00; // RULE4
        end else if (pre.src_tick) begin
            n.cnt = s.cnt + 7'h01;
        end
    end

    // Clear suppresses the tick so the restart cycle never counts twice
    assign pre.tick = pre.src_tick && !pre.clear && ((s.cnt & mask) == mask); // RULE2

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : pwt_prescaler

`default_nettype wire

// ---- src/pwt_timer.sv ----
// Pulse width timer: 16-bit counter, edge capture, read buffers and register port.
// Assumes a byte-wide register port with read data one cycle after the read strobe.
//
// How it works
// [RULE1] 16-bit free-running counter on divided clock
// [RULE2] Prescaler divides by 1 to 128
// [RULE3] Clock source bus clock or alternative clock
// [RULE4] Measured edge captures counter, then restarts it
// [RULE5] Overflow flag on wrap to zero
// [RULE6] Mode 00: falling edges capture positive register
// [RULE7] Mode 11: rising edges capture negative register
// [RULE8] Mode 01: rising start, both edges capture
// [RULE9] Mode 10: falling start, both edges capture
// [RULE10] Two-bit select picks one of four inputs
// [RULE11] Ready flag set per edge mode pairing
// [RULE12] Ready copies widths into read buffers
// [RULE13] Buffers frozen while ready flag set
// [RULE14] Read then write 0 clears; set wins
// [RULE15] Counter byte read latches coherent 16 bits
// [RULE16] Latches restart on reset, soft reset, disable
// [RULE17] Debug halt freezes latch, reads live counter
// [RULE18] Counter cleared one cycle after capture
// [RULE19] Soft reset clears counter, widths, flags
// [RULE20] Disable acts as held soft reset
// [RULE21] Interrupt request gated by enables
// [RULE22] Software enables module after configuring
// [RULE23] Edge mode change needs soft reset
// [RULE24] Pulses shorter than one tick ignored
// [RULE25] Alternative clock synchronised, below quarter rate
//
// The implementer's own choice: strobed register access.
`include "pwt_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pwt_timer #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic [3:0] pulse_input,
    input wire logic alternative_clock_input,
    input wire logic debug_halt_mode,
    output logic irq
);
    pwt_pkg::pwt_main_t s;
    pwt_pkg::pwt_main_t n;
    pwt_pre_if pre_link ();

    logic wr_cs;
    logic soft_clr;
    logic rdy_clr;
    logic tick;
    logic sampled;
    logic rise;
    logic fall;
    logic cap_pos;
    logic cap_neg;
    logic rdy_set;
    logic [1:0] edge_mode;
    logic [15:0] pos_n;
    logic [15:0] neg_n;

    pwt_prescaler u_pre (
        .clk(clk),
        .nrst(nrst),
        .pre(pre_link.pre)
    );

    // ==========================================
    // Prescaler link
    assign edge_mode = s.cr[`PWT_CR_EDGE_HI:`PWT_CR_EDGE_LO];
    assign wr_cs = wr_en && (addr == `PWT_OFS_CTRL_STATUS);
    assign soft_clr = (wr_cs && wr_data[`PWT_CS_SR]) || !s.en; // RULE19 RULE20
    // Alternative clock counts on its synchronised rising edge, hence the quarter-rate limit
    assign pre_link.src_tick = s.en && !debug_halt_mode &&
        (s.cr[`PWT_CR_CLKSEL] ? (s.alt_s2 && !s.alt_s3) : 1'b1); // RULE3 RULE25
    assign pre_link.clear = s.clr || soft_clr; // RULE18
    assign pre_link.div = s.cr[`PWT_CR_DIV_HI:`PWT_CR_DIV_LO];
    assign tick = pre_link.tick;

    // ==========================================
    // Edge detection, sampled on the divided clock
    assign sampled = pulse_input[s.cr[`PWT_CR_PIN_HI:`PWT_CR_PIN_LO]]; // RULE10
    // Edges count only once a first tick has taken the level, so a restart never sees a false edge
    assign rise = tick && s.in_vld && sampled && !s.in_q; // RULE24
    assign fall = tick && s.in_vld && !sampled && s.in_q; // RULE24
    assign cap_pos = (s.st == pwt_pkg::PWT_ST_RUN) && fall &&
        (edge_mode != `PWT_EDGE_RISE_PERIOD); // RULE6 RULE8 RULE9
    assign cap_neg = (s.st == pwt_pkg::PWT_ST_RUN) && rise &&
        (edge_mode != `PWT_EDGE_FALL_PERIOD); // RULE7 RULE8 RULE9
    assign rdy_clr = wr_cs && !wr_data[`PWT_CS_RDY] && s.rdy && s.rdy_seen; // RULE14
    assign pos_n = cap_pos ? s.cnt : s.pos;
    assign neg_n = cap_neg ? s.cnt : s.neg;

    always_comb begin
        rdy_set = 1'b0;
        case (edge_mode)
            `PWT_EDGE_FALL_PERIOD: begin
                rdy_set = cap_pos; // RULE11
            end
            `PWT_EDGE_RISE_PERIOD: begin
                rdy_set = cap_neg; // RULE11
            end
            `PWT_EDGE_RISE_FIRST: begin
                rdy_set = cap_neg && s.half; // RULE11
            end
            `PWT_EDGE_FALL_FIRST: begin
                rdy_set = cap_pos && s.half; // RULE11
            end
            default: begin
                rdy_set = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        n = s;
        n.alt_s1 = alternative_clock_input; // RULE25
        n.alt_s2 = s.alt_s1;
        n.alt_s3 = s.alt_s2;
        n.rd_data = `PWT_RST_BYTE;
        n.clr = 1'b0;

        // Register writes
        if (wr_cs) begin
            n.en = wr_data[`PWT_CS_EN];
            n.ie = wr_data[`PWT_CS_IE];
            n.rdyie = wr_data[`PWT_CS_RDYIE];
            n.ovie = wr_data[`PWT_CS_OVIE];
            if (rdy_clr) begin
                n.rdy = 1'b0; // RULE14
                n.rdy_seen = 1'b0;
            end
            if (!wr_data[`PWT_CS_OV]) begin
                n.ov = 1'b0;
            end
        end
        if (wr_en && (addr == `PWT_OFS_CONTROL)) begin
            n.cr = wr_data;
        end

        // Register reads
        if (rd_en) begin
            case (addr)
                `PWT_OFS_CTRL_STATUS: begin
                    n.rd_data = {s.en, s.ie, s.rdyie, s.ovie, 2'h0, s.rdy, s.ov};
                    if (s.rdy) begin
                        n.rdy_seen = 1'b1;
                    end
                end
                `PWT_OFS_CONTROL: begin
                    n.rd_data = s.cr;
                end
                `PWT_OFS_POS_HIGH: begin
                    n.rd_data = s.pos_buf[15:8]; // RULE12
                end
                `PWT_OFS_POS_LOW: begin
                    n.rd_data = s.pos_buf[7:0]; // RULE12
                end
                `PWT_OFS_NEG_HIGH: begin
                    n.rd_data = s.neg_buf[15:8]; // RULE12
                end
                `PWT_OFS_NEG_LOW: begin
                    n.rd_data = s.neg_buf[7:0]; // RULE12
                end
                `PWT_OFS_CNT_HIGH, `PWT_OFS_CNT_LOW: begin
                    if (debug_halt_mode) begin
                        n.rd_data = addr[0] ? s.cnt[7:0] : s.cnt[15:8]; // RULE17
                    end else if (!s.lat) begin
                        n.rd_data = addr[0] ? s.cnt[7:0] : s.cnt[15:8]; // RULE15
                        n.cnt_buf = s.cnt;
                        n.lat = 1'b1;
                        n.lat_low_first = addr[0];
                    end else begin
                        n.rd_data = addr[0] ? s.cnt_buf[7:0] : s.cnt_buf[15:8]; // RULE15
                        if (addr[0] != s.lat_low_first) begin
                            n.lat = 1'b0;
                        end
                    end
                end
                default: begin
                    n.rd_data = `PWT_RST_BYTE;
                end
            endcase
        end

        // Measurement
        if (soft_clr) begin
            n.cnt = `PWT_RST_WORD; // RULE16 RULE19 RULE20
            n.cnt_buf = `PWT_RST_WORD;
            n.lat = 1'b0;
            n.lat_low_first = 1'b0;
            n.pos = `PWT_RST_WORD;
            n.neg = `PWT_RST_WORD;
            n.pos_buf = `PWT_RST_WORD;
            n.neg_buf = `PWT_RST_WORD;
            n.rdy = 1'b0;
            n.rdy_seen = 1'b0;
            n.ov = 1'b0;
            n.st = pwt_pkg::PWT_ST_WAIT;
            n.half = 1'b0;
            n.in_q = 1'b0;
            n.in_vld = 1'b0;
        end else begin
            if (s.clr) begin
                n.cnt = `PWT_RST_WORD; // RULE18
            end else if (tick) begin
                n.cnt = s.cnt + 16'h0001; // RULE1
                if (s.cnt == `PWT_CNT_MAX) begin
                    n.ov = 1'b1; // RULE5
                end
            end
            if (tick) begin
                n.in_q = sampled;
                n.in_vld = 1'b1;
            end
            case (s.st)
                pwt_pkg::PWT_ST_WAIT: begin
                    // The input level before the first tick is unknown, so wait for a real edge
                    if ((rise && (edge_mode == `PWT_EDGE_RISE_PERIOD || edge_mode == `PWT_EDGE_RISE_FIRST)) ||
                        (fall && (edge_mode == `PWT_EDGE_FALL_PERIOD || edge_mode == `PWT_EDGE_FALL_FIRST))) begin
                        n.st = pwt_pkg::PWT_ST_RUN; // RULE6 RULE7 RULE8 RULE9
                        n.clr = 1'b1;
                    end
                end
                pwt_pkg::PWT_ST_RUN: begin
                    if (cap_pos || cap_neg) begin
                        n.pos = pos_n; // RULE4
                        n.neg = neg_n;
                        n.clr = 1'b1; // RULE18
                        n.half = rdy_set ? 1'b0 :
                            ((edge_mode == `PWT_EDGE_RISE_FIRST) ? cap_pos : cap_neg);
                    end
                end
                default: begin
                    n.st = pwt_pkg::PWT_ST_WAIT;
                end
            endcase
            if (rdy_set) begin
                n.rdy = 1'b1; // RULE11 RULE14
                n.rdy_seen = 1'b0;
                if (!s.rdy || rdy_clr) begin
                    n.pos_buf = pos_n; // RULE12 RULE13 RULE14
                    n.neg_buf = neg_n;
                end
            end
        end

        n.irq = n.ie && ((n.ov && n.ovie) || (n.rdy && n.rdyie)); // RULE21
    end

    // ==========================================
    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.st <= pwt_pkg::PWT_ST_WAIT;
        end else begin
            s <= n;
        end
    end

    assign rd_data = s.rd_data;
    assign irq = s.irq;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ovf_on_wrap_a: assert property (tick && !s.clr && !soft_clr && s.cnt == `PWT_CNT_MAX |=> s.ov) // RULE5
        else $error("overflow flag missed on wrap");
    clear_after_cap_a: assert property ((cap_pos || cap_neg) && !soft_clr |=> s.clr ##1 s.cnt == 16'h0000) // RULE18
        else $error("counter not cleared after capture");
    soft_clear_a: assert property (wr_cs && wr_data[`PWT_CS_SR] |=>
        s.cnt == 16'h0000 && s.pos == 16'h0000 && s.neg == 16'h0000 && !s.rdy && !s.ov) // RULE19
        else $error("soft reset left state behind");
    disable_hold_a: assert property (!s.en |=> s.cnt == 16'h0000 && s.pos_buf == 16'h0000 && !s.lat) // RULE20
        else $error("disabled timer not held cleared");
    buf_hold_a: assert property (s.rdy && !rdy_clr && !soft_clr |=> $stable(s.pos_buf) && $stable(s.neg_buf)) // RULE13
        else $error("read buffer refreshed while ready");
    set_wins_a: assert property (rdy_set && !soft_clr |=> s.rdy &&
        ((s.pos_buf == $past(pos_n) && s.neg_buf == $past(neg_n)) || ($past(s.rdy) && !$past(rdy_clr)))) // RULE14
        else $error("ready set lost or buffer stale");
    irq_gate_a: assert property (irq == (s.ie && ((s.ov && s.ovie) || (s.rdy && s.rdyie)))) // RULE21
        else $error("interrupt request mismatch");
    cnt_latch_a: assert property (rd_en && addr == `PWT_OFS_CNT_HIGH && !s.lat && !debug_halt_mode && !soft_clr |=>
        s.lat && s.cnt_buf == $past(s.cnt) && rd_data == $past(s.cnt[15:8])) // RULE15
        else $error("counter latch not coherent");
    halt_freeze_a: assert property (debug_halt_mode && !soft_clr && !s.clr |=> $stable(s.cnt) && $stable(s.lat)) // RULE17
        else $error("counter moved in debug halt");
    mode00_ready_a: assert property (cap_pos && edge_mode == `PWT_EDGE_FALL_PERIOD && !soft_clr |=>
        s.rdy && s.pos == $past(s.cnt)) // RULE6
        else $error("period capture did not set ready");
endmodule : pwt_timer

`default_nettype wire

// ---- tb/pulse_width_timer_test.sv ----
// Bench of the pulse width timer: register port tasks and measurement scenarios.
// Assumes pwt_src drives the measured inputs and a 10 MHz bus clock.
`include "pwt_defs.svh"
`timescale 1ns/1ns
`default_nettype none
`define PWT_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end

module pulse_width_timer_test;
    logic clk;
    logic nrst;
    logic [2:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    logic [3:0] pulse_input;
    logic alternative_clock_input;
    logic debug_halt_mode;
    logic irq;
    logic run;
    logic [1:0] sel;
    logic [7:0] hi_len;
    logic [7:0] lo_len;
    logic [7:0] b;
    logic [15:0] v1;
    logic [15:0] v2;
    logic [15:0] v3;
    int n_errors;
    int checks_done;
    int pos_e[4] = '{17, 5, 5, 0};
    int neg_e[4] = '{0, 10, 10, 17};

    pwt_timer #(.CNT_W(16)) u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .pulse_input(pulse_input),
        .alternative_clock_input(alternative_clock_input), .debug_halt_mode(debug_halt_mode), .irq(irq));
    pwt_src u_src (.clk(clk), .nrst(nrst), .run(run), .sel(sel), .hi_len(hi_len), .lo_len(lo_len),
        .pulse_input(pulse_input), .alternative_clock_input(alternative_clock_input));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ====================
    // Register port
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    // High byte first; takes are two cycles apart
    task automatic rd16(input logic [2:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 3'h1, v[7:0]);
    endtask : rd16

    task automatic wait_cs(input int bitn);
        int i;
        logic [7:0] s;
        for (i = 0; i < 600; i++) begin
            rd(`PWT_OFS_CTRL_STATUS, s);
            if (s[bitn] === 1'b1) break;
        end
        if (i == 600) begin
            n_errors++;
            $display("unexpected at %0t: flag %0d never set", $time, bitn);
            end_sim();
        end
    endtask : wait_cs

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // ====================
    // Main sequence
    initial begin
        nrst = 1'b0;
        addr = 3'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        debug_halt_mode = 1'b0;
        run = 1'b0;
        sel = 2'h0;
        hi_len = 8'h07;
        lo_len = 8'h0C;
        n_errors = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        wr(`PWT_OFS_CNT_HIGH, 8'hFF);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), b);
            `PWT_CHK(b, `PWT_RST_BYTE)
        end
        $display("test reset done");
        // Gaps are whole prescaler periods, so the tick count is exact
        for (int d = 0; d < 8; d++) begin
            wr(`PWT_OFS_CONTROL, 8'(d));
            wr(`PWT_OFS_CTRL_STATUS, 8'h80);
            rd16(`PWT_OFS_CNT_HIGH, v1);
            repeat ((16 << d) - 4) @(posedge clk);
            rd16(`PWT_OFS_CNT_HIGH, v2);
            `PWT_CHK(16'(v2 - v1), 16'h0010)
        end
        wr(`PWT_OFS_CONTROL, 8'h80);
        rd16(`PWT_OFS_CNT_HIGH, v1);
        repeat (60) @(posedge clk);
        rd16(`PWT_OFS_CNT_HIGH, v2);
        `PWT_CHK(16'(v2 - v1), 16'h0010)
        $display("test prescaler done");
        wr(`PWT_OFS_CONTROL, 8'h00);
        rd16(`PWT_OFS_CNT_HIGH, v1);
        rd(`PWT_OFS_CNT_LOW, b);
        repeat (300) @(posedge clk);
        rd(`PWT_OFS_CNT_HIGH, v2[15:8]);
        `PWT_CHK({v2[15:8], b}, 16'(v1 + 16'h0004))
        rd16(`PWT_OFS_CNT_HIGH, v1);
        rd(`PWT_OFS_CNT_HIGH, b);
        repeat (300) @(posedge clk);
        debug_halt_mode <= 1'b1;
        repeat (4) @(posedge clk);
        rd16(`PWT_OFS_CNT_HIGH, v2);
        repeat (20) @(posedge clk);
        rd16(`PWT_OFS_CNT_HIGH, v3);
        `PWT_CHK(v3, v2)
        `PWT_CHK(16'(v2 - v1) > 16'd300, 1'b1)
        @(posedge clk);
        debug_halt_mode <= 1'b0;
        rd(`PWT_OFS_CNT_LOW, b);
        `PWT_CHK(b, 8'(v1 + 16'h0004))
        $display("test counter read done");
        @(posedge clk);
        run <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            sel <= 2'(m);
            wr(`PWT_OFS_CONTROL, 8'((m << 5) | (m << 3)));
            wr(`PWT_OFS_CTRL_STATUS, 8'hE8);
            rd16(`PWT_OFS_POS_HIGH, v1);
            `PWT_CHK(v1, `PWT_RST_WORD)
            wait_cs(`PWT_CS_RDY);
            rd16(`PWT_OFS_POS_HIGH, v1);
            rd16(`PWT_OFS_NEG_HIGH, v2);
            `PWT_CHK(v1, 16'(pos_e[m]))
            `PWT_CHK(v2, 16'(neg_e[m]))
            `PWT_CHK(irq, 1'b1)
        end
        $display("test edge modes done");
        @(posedge clk);
        hi_len <= 8'd20;
        repeat (200) @(posedge clk);
        rd16(`PWT_OFS_NEG_HIGH, v2);
        `PWT_CHK(v2, 16'd17)
        rd(`PWT_OFS_CTRL_STATUS, b);
        wr(`PWT_OFS_CTRL_STATUS, 8'h80);
        wait_cs(`PWT_CS_RDY);
        rd16(`PWT_OFS_NEG_HIGH, v2);
        `PWT_CHK(v2, 16'd30)
        `PWT_CHK(irq, 1'b0)
        wr(`PWT_OFS_CTRL_STATUS, 8'h00);
        rd16(`PWT_OFS_NEG_HIGH, v2);
        `PWT_CHK(v2, `PWT_RST_WORD)
        rd16(`PWT_OFS_CNT_HIGH, v2);
        `PWT_CHK(v2, `PWT_RST_WORD)
        rd(`PWT_OFS_CTRL_STATUS, b);
        `PWT_CHK(b, `PWT_RST_BYTE)
        $display("test buffering done");
        @(posedge clk);
        run <= 1'b0;
        wr(`PWT_OFS_CTRL_STATUS, 8'h98);
        repeat (65000) @(posedge clk);
        rd(`PWT_OFS_CTRL_STATUS, b);
        `PWT_CHK(b, 8'h90)
        wait_cs(`PWT_CS_OV);
        `PWT_CHK(irq, 1'b0)
        wr(`PWT_OFS_CTRL_STATUS, 8'hD1);
        repeat (2) @(posedge clk);
        rd(`PWT_OFS_CTRL_STATUS, b);
        `PWT_CHK(b, 8'hD1)
        `PWT_CHK(irq, 1'b1)
        wr(`PWT_OFS_CTRL_STATUS, 8'hD0);
        repeat (2) @(posedge clk);
        rd(`PWT_OFS_CTRL_STATUS, b);
        `PWT_CHK(b, 8'hD0)
        `PWT_CHK(irq, 1'b0)
        $display("test overflow done");
        end_sim();
    end
endmodule : pulse_width_timer_test

`default_nettype wire

// ---- tb/pwt_src.sv ----
// Pulse source model: drives the four measured inputs and the alternative clock.
// Assumes the bench changes lengths and select by non-blocking assignment on clk.
`timescale 1ns/1ns
`default_nettype none

module pwt_src (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [1:0] sel,
    input wire logic [7:0] hi_len,
    input wire logic [7:0] lo_len,
    output var logic [3:0] pulse_input,
    output var logic alternative_clock_input
);
    logic [7:0] cnt_q;
    logic lvl_q;
    logic [1:0] alt_q;

    // ====================
    // Wave generation
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            lvl_q <= 1'b1;
            alt_q <= 2'h0;
        end else begin
            alt_q <= alt_q + 2'h1;
            if (run) begin
                if (cnt_q + 8'h01 >= (lvl_q ? hi_len : lo_len)) begin
                    cnt_q <= 8'h00;
                    lvl_q <= ~lvl_q;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

    // Unselected inputs toggle every cycle, so a wrong select is never quiet
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pulse_input[i] = (2'(i) == sel) ? lvl_q : alt_q[0];
        end
    end

    // A quarter of the bus clock, the fastest the alternative clock may run
    assign alternative_clock_input = alt_q[1];
endmodule : pwt_src

`default_nettype wire
